// File: aas_defines.vh
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH
`define AAS_ADDR_CTRL      4'h0
`define AAS_ADDR_COND      4'h4
`define AAS_ADDR_FLAGS     4'h8
`define AAS_ADDR_EVENT     4'hC
`define AAS_BIT_SUPPLY     0
`define AAS_BIT_SHORTDET   1
`define AAS_BIT_RECOVER    2
`define AAS_BIT_OPENDET    3
`define AAS_CTRL_RESET     4'h0
`define AAS_COND_INIT      2'h0
`define AAS_COND_OK        2'h1
`define AAS_COND_SHORT     2'h2
`define AAS_COND_OPEN      2'h3
`define AAS_RESP_OKAY      2'h0
`define AAS_RESP_SLVERR    2'h2
`define AAS_RECOVER_CYCLES 1000000
`endif

// File: aas_supervisor.v
// Operation
// - four enables, writing 1 turns function on
// - no condition reports while supply control off
// - cut output high removes power, else low
// - short sense active low, low means short
// - short without power-down: report, keep power
// - short stays latched until recovery, reset, toggle
// - recovery enabled: short cuts supply, reports SHORT
// - after timeout restore power, resample, OK
// - presence low gives OPEN, high gives OK
// - report INIT first, then OK when fault-free
// - capability flags shown only for enabled functions
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`include "aas_defines.vh"
module aas_supervisor #(
  parameter RECOVER_CYCLES = `AAS_RECOVER_CYCLES
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        short_sense_n,
  input  wire        presence_sense_pin,
  output reg         supply_cut_out,
  output reg  [1:0]  condition_report,
  output wire [4:0]  supervisor_flags_report,
  output reg         condition_event,
  input  wire [3:0]  s_axil_awaddr,
  input  wire        s_axil_awvalid,
  output wire        s_axil_awready,
  input  wire [31:0] s_axil_wdata,
  input  wire [3:0]  s_axil_wstrb,
  input  wire        s_axil_wvalid,
  output wire        s_axil_wready,
  output reg  [1:0]  s_axil_bresp,
  output reg         s_axil_bvalid,
  input  wire        s_axil_bready,
  input  wire [3:0]  s_axil_araddr,
  input  wire        s_axil_arvalid,
  output wire        s_axil_arready,
  output reg  [31:0] s_axil_rdata,
  output reg  [1:0]  s_axil_rresp,
  output reg         s_axil_rvalid,
  input  wire        s_axil_rready
);
  localparam ST_INIT  = 4'b0001;
  localparam ST_RUN   = 4'b0010;
  localparam ST_CUT   = 4'b0100;
  localparam ST_RETRY = 4'b1000;

  reg  [3:0]  ctrl;
  reg  [1:0]  short_sync;
  reg  [1:0]  pres_sync;
  reg  [3:0]  state;
  reg  [31:0] timer;
  reg         short_latched;
  reg         prev_shortdet;
  reg  [31:0] event_count;
  reg  [1:0]  next_cond;

  wire supply_en   = ctrl[`AAS_BIT_SUPPLY];
  wire shortdet_en = ctrl[`AAS_BIT_SHORTDET];
  wire recover_en  = ctrl[`AAS_BIT_RECOVER];
  wire opendet_en  = ctrl[`AAS_BIT_OPENDET];
  wire short_now   = shortdet_en & ~short_sync[1];
  wire open_now    = opendet_en & ~pres_sync[1];

  // flags: supply, short, open, power-down-on-short, recovery
  assign supervisor_flags_report = {recover_en & shortdet_en, recover_en & shortdet_en,
                                    opendet_en, shortdet_en, supply_en};

  // two-stage synchronisers, only the second stage is read
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      short_sync <= 2'h3;
      pres_sync  <= 2'h3;
    end else begin
      short_sync <= {short_sync[0], short_sense_n};
      pres_sync  <= {pres_sync[0], presence_sense_pin};
    end
  end

  // write channel: both address and data must be present
  wire wr_go = s_axil_awvalid & s_axil_wvalid & ~s_axil_bvalid;
  assign s_axil_awready = wr_go;
  assign s_axil_wready  = wr_go;
  wire rd_go = s_axil_arvalid & ~s_axil_rvalid;
  assign s_axil_arready = rd_go;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl          <= `AAS_CTRL_RESET;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= `AAS_RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axil_bvalid <= 1'b1;
        if (s_axil_awaddr == `AAS_ADDR_CTRL) begin
          s_axil_bresp <= `AAS_RESP_OKAY;
          if (s_axil_wstrb[0])
            ctrl <= s_axil_wdata[3:0];
        end else begin
          s_axil_bresp <= `AAS_RESP_SLVERR;
        end
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h00000000;
      s_axil_rresp  <= `AAS_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= `AAS_RESP_OKAY;
        case (s_axil_araddr)
          `AAS_ADDR_CTRL:  s_axil_rdata <= {28'h0000000, ctrl};
          `AAS_ADDR_COND:  s_axil_rdata <= {29'h00000000, supply_cut_out, condition_report};
          `AAS_ADDR_FLAGS: s_axil_rdata <= {27'h0000000, supervisor_flags_report};
          `AAS_ADDR_EVENT: s_axil_rdata <= event_count;
          default: begin
            s_axil_rdata <= 32'h00000000;
            s_axil_rresp <= `AAS_RESP_SLVERR;
          end
        endcase
      end else if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

  // condition computed from latched or live short and live open sense
  always @* begin
    // a fresh short is reported in the same edge as the cut, never after it
    if (short_latched || short_now)
      next_cond = `AAS_COND_SHORT;
    else if (open_now)
      next_cond = `AAS_COND_OPEN;
    else
      next_cond = `AAS_COND_OK;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state            <= ST_INIT;
      condition_report <= `AAS_COND_INIT;
      supply_cut_out   <= 1'b0;
      short_latched    <= 1'b0;
      prev_shortdet    <= 1'b0;
      timer            <= 32'h00000000;
      condition_event  <= 1'b0;
      event_count      <= 32'h00000000;
    end else begin
      prev_shortdet   <= shortdet_en;
      condition_event <= 1'b0;
      case (state)
        ST_INIT: begin
          supply_cut_out   <= 1'b0;
          short_latched    <= 1'b0;
          condition_report <= `AAS_COND_INIT;
          if (supply_en)
            state <= ST_RUN;
        end
        ST_RUN: begin
          supply_cut_out <= 1'b0;
          if (!supply_en) begin
            state <= ST_INIT;
          end else if (shortdet_en && !prev_shortdet) begin
            short_latched <= 1'b0;
          end else if (short_now && recover_en) begin
            short_latched  <= 1'b1;
            supply_cut_out <= 1'b1;
            timer          <= 32'h00000000;
            state          <= ST_CUT;
          end else if (short_now) begin
            short_latched <= 1'b1;
          end
          if (supply_en && (condition_report != next_cond)) begin
            condition_report <= next_cond;
            condition_event  <= 1'b1;
            event_count      <= event_count + 32'h00000001;
          end
        end
        ST_CUT: begin
          supply_cut_out <= 1'b1;
          if (!supply_en) begin
            state <= ST_INIT;
          end else if (!recover_en || !shortdet_en) begin
            supply_cut_out <= 1'b0;
            short_latched  <= 1'b0;
            state          <= ST_RUN;
          end else if (timer >= RECOVER_CYCLES - 1) begin
            supply_cut_out <= 1'b0;
            timer          <= 32'h00000000;
            state          <= ST_RETRY;
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_RETRY: begin
          // sense path needs sync delay plus settling before resampling
          supply_cut_out <= 1'b0;
          if (timer >= 32'h00000003) begin
            timer <= 32'h00000000;
            if (short_now) begin
              supply_cut_out <= 1'b1;
              state          <= ST_CUT;
            end else begin
              short_latched <= 1'b0;
              state         <= ST_RUN;
            end
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        default: state <= ST_INIT;
      endcase
    end
  end
endmodule

// File: aas_antenna_model.sv
module aas_antenna_model (
  input  wire  supply_cut_out,
  input  wire  short_fault,
  input  wire  open_fault,
  output logic short_sense_n,
  output logic presence_sense_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a cut supply draws no current, so the pull-up wins while cut
  assign short_sense_n = !(short_fault && !supply_cut_out);
  assign presence_sense_pin = !open_fault;
endmodule

// File: aas_supervisor_sva.sv
module aas_supervisor_sva (
  input wire       sys_clk,
  input wire       sys_rst,
  input wire       supply_cut_out,
  input wire [1:0] condition_report,
  input wire [4:0] supervisor_flags_report,
  input wire       condition_event,
  input wire       s_axil_awvalid,
  input wire       s_axil_awready,
  input wire       s_axil_wvalid,
  input wire       s_axil_bvalid,
  input wire       s_axil_arvalid,
  input wire       s_axil_arready,
  input wire       s_axil_rvalid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr; s_axil_awvalid && s_axil_awready && s_axil_wvalid; endsequence
  property p_wr; s_wr |=> s_axil_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd; s_axil_arvalid && s_axil_arready |=> s_axil_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_ar; s_axil_rvalid |-> !s_axil_arready; endproperty
  a_ar: assert property (p_ar) else $error("read taken while pending");
  property p_ok; condition_report == 2'h1 |-> !supply_cut_out; endproperty
  a_ok: assert property (p_ok) else $error("cut while ok");
  property p_cut; supply_cut_out |-> condition_report == 2'h2; endproperty
  a_cut: assert property (p_cut) else $error("cut without short");
  property p_init; condition_report == 2'h0 |-> !supply_cut_out && !condition_event; endproperty
  a_init: assert property (p_init) else $error("activity in init");
  property p_flag; supervisor_flags_report[4] |-> &supervisor_flags_report[3:1] | supervisor_flags_report[1] & supervisor_flags_report[3]; endproperty
  a_flag: assert property (p_flag) else $error("flag set mismatch");
  property p_evt; condition_event |=> !condition_event; endproperty
  a_evt: assert property (p_evt) else $error("event too long");
endmodule
bind aas_supervisor aas_supervisor_sva u_sva (.*);

// File: tb_active_antenna_supervisor.sv
module tb_active_antenna_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 20;
  logic sys_clk = 0, sys_rst = 1, short_fault = 0, open_fault = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0;
  logic [3:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic [31:0] s_axil_wdata = 0;
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  wire short_sense_n, presence_sense_pin, supply_cut_out, condition_event;
  wire [1:0] condition_report, s_axil_bresp, s_axil_rresp;
  wire [4:0] supervisor_flags_report;
  wire [31:0] s_axil_rdata;
  int n_errors = 0, comparisons = 0;
  aas_supervisor #(.RECOVER_CYCLES(RC)) DUT (.*, .s_axil_wstrb(4'hF));
  aas_antenna_model u_ant (.*);
  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    #200000 n_errors++;
    summarize();
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1;
    s_axil_wvalid <= 1;
    do @(posedge sys_clk); while (s_axil_awready !== 1);
    s_axil_awvalid <= 0;
    s_axil_wvalid <= 0;
    s_axil_bready <= 1;
    do @(posedge sys_clk); while (s_axil_bvalid !== 1);
    s_axil_bready <= 0;
    chk(s_axil_bresp, 32'h0);
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1;
    do @(posedge sys_clk); while (s_axil_arready !== 1);
    s_axil_arvalid <= 0;
    s_axil_rready <= 1;
    do @(posedge sys_clk); while (s_axil_rvalid !== 1);
    s_axil_rready <= 0;
    chk(s_axil_rdata, e);
  endtask
  // bounded wait, the sense path adds a few sync cycles
  task wc(input logic [1:0] v, input int n);
    for (int i = 0; i < n && condition_report !== v; i++) @(posedge sys_clk);
    chk(condition_report, v);
  endtask
  task t_init;
    rdc(4'h0, 32'h0);
    rdc(4'h4, 32'h0);
    rdc(4'h8, 32'h0);
    wr(4'h0, 32'h1);
    wc(2'h1, 40);
    rdc(4'h8, 32'h1);
    $display("init test done");
  endtask
  task t_short;
    wr(4'h0, 32'h3);
    short_fault <= 1;
    wc(2'h2, 40);
    chk(supply_cut_out, 32'h0);
    short_fault <= 0;
    repeat (10) @(posedge sys_clk);
    chk(condition_report, 32'h2);
    wr(4'h0, 32'h1);
    wr(4'h0, 32'h3);
    wc(2'h1, 40);
    $display("short test done");
  endtask
  task t_recover;
    wr(4'h0, 32'h7);
    rdc(4'h8, 32'h1B);
    short_fault <= 1;
    wc(2'h2, 40);
    chk(supply_cut_out, 32'h1);
    rdc(4'h4, 32'h6);
    short_fault <= 0;
    wc(2'h1, RC + 60);
    chk(supply_cut_out, 32'h0);
    $display("recover test done");
  endtask
  task t_open;
    wr(4'h0, 32'hF);
    rdc(4'h8, 32'h1F);
    open_fault <= 1;
    wc(2'h3, 40);
    open_fault <= 0;
    wc(2'h1, 40);
    wr(4'h0, 32'h0);
    wc(2'h0, 40);
    rdc(4'hC, 32'h7);
    $display("open test done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 0;
    t_init();
    t_short();
    t_recover();
    t_open();
    summarize();
  end
endmodule
